/* src/ddr_memory_pins_and_startup.sv */
// DDR pad side, startup sequencer and register port of the hard memory controller
//
// Notes on behaviour
// - Sequencer stays idle while the sequencer reset input is high.
// - Startup sequence begins when the sequencer go input rises.
// - Master reset is active low; memory access waits until reconfigured.
// - Drive 16-bit address bus and 3-bit bank bus to memory.
// - Row, column, write strobes and chip select are active low.
// - Memory clock enable is active high.
// - Complementary clock pair matches the controller's own stepping clock.
// - Active-high byte masks, one per data byte.
// - Differential strobes driven on writes, released for the memory on reads.
// - Active-low memory reset output and separate termination control output.
`timescale 1ns/1ps
module ddr_memory_pins_and_startup
  import ddr_pins_pkg::*;
#(
  parameter int DQ_W = 16,
  parameter logic [15:0] RST_HOLD_CYC = 16'h00C8,
  parameter logic [15:0] CKE_WAIT_CYC = 16'h0020,
  parameter logic [15:0] MRD_CYC = 16'h0004,
  parameter logic [15:0] ZQ_CYC = 16'h0040,
  parameter logic [15:0] TRCD_CYC = 16'h0002,
  parameter logic [15:0] CL_CYC = 16'h0005,
  parameter logic [15:0] CWL_CYC = 16'h0005,
  parameter logic [15:0] BEATS = 16'h0004,
  parameter logic [15:0] TRP_CYC = 16'h0002,
  parameter logic [15:0] MR0_VAL = 16'h0000,
  parameter logic [15:0] MR1_VAL = 16'h0000,
  parameter logic [15:0] MR2_VAL = 16'h0000,
  parameter logic [15:0] MR3_VAL = 16'h0000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [REG_DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [REG_DATA_W-1:0] regRdata,
  input wire logic startupSequencerReset,
  input wire logic startupSequencerGo,
  input wire logic cfgRstN,
  input wire logic cfgSerialClkIn,
  input wire logic cfgSerialDataIn,
  output logic cfgSerialDataDriveEn,
  input wire logic phyFastClock,
  output logic [MEM_ADDR_W-1:0] memAddr,
  output logic [MEM_BANK_W-1:0] memBank,
  output logic memCsN,
  output logic memRasN,
  output logic memCasN,
  output logic memWeN,
  output logic memCke,
  output logic memClkP,
  output logic memClkN,
  output logic [DQ_W-1:0] memDqOut,
  output logic memDqOe,
  input wire logic [DQ_W-1:0] memDqIn,
  output logic [DQ_W/8-1:0] memByteMask,
  output logic [DQ_W/8-1:0] memStrobeOut,
  output logic [DQ_W/8-1:0] memStrobeNOut,
  output logic memStrobeOe,
  output logic memTerminationCtl,
  output logic memRstN,
  input wire logic memCalPinIn,
  output logic memCalPinOut,
  output logic memCalPinOe
);

  localparam int STROBE_W = DQ_W / 8;
  localparam logic [15:0] CAP_CNT = BEATS - 16'h0002;

  function automatic logic [MEM_BANK_W-1:0] mrsBank(input logic [1:0] idx);
    unique case (idx)
      2'h0: mrsBank = 3'h2;
      2'h1: mrsBank = 3'h3;
      2'h2: mrsBank = 3'h1;
      default: mrsBank = 3'h0;
    endcase
  endfunction

  function automatic logic [MEM_ADDR_W-1:0] mrsValue(input logic [1:0] idx);
    unique case (idx)
      2'h0: mrsValue = MR2_VAL;
      2'h1: mrsValue = MR3_VAL;
      2'h2: mrsValue = MR1_VAL;
      default: mrsValue = MR0_VAL;
    endcase
  endfunction

  // ****************************************
  // System domain: register port
  // ****************************************
  logic [REG_DATA_W-1:0] colReg_r;
  logic [REG_DATA_W-1:0] wdataReg_r;
  logic [REG_DATA_W-1:0] rdataReg_r;
  logic cfgDrive_r;
  logic busy_r;
  logic reqTog_r;
  logic donePrev_r;
  memreq_t sysReq_r;
  logic [2:0] pinSync;
  logic [1:0] phySync;
  logic readySync;
  logic doneSync;
  logic readyLvl_r;
  logic doneTog_r;
  logic [DQ_W-1:0] rdHold_r;

  sync_two_flop #(.WIDTH(3)) u_pin_sync (
    .clk(clk),
    .rstn(rstn),
    .d({memCalPinIn, cfgSerialDataIn, cfgSerialClkIn}),
    .q(pinSync)
  );

  sync_two_flop #(.WIDTH(2)) u_phy_status_sync (
    .clk(clk),
    .rstn(rstn),
    .d({doneTog_r, readyLvl_r}),
    .q(phySync)
  );

  assign readySync = phySync[0];
  assign doneSync = phySync[1];

  wire wrCmd = regWr && (regAddr == REG_CMD);
  wire wrCol = regWr && (regAddr == REG_COL);
  wire wrWdata = regWr && (regAddr == REG_WDATA);
  wire wrCfg = regWr && (regAddr == REG_CFG);
  wire doneEvt = doneSync ^ donePrev_r;
  // Access refused until the sequencer has rerun after any reset
  wire issue = wrCmd && regWdata[CMD_GO_BIT] && readySync && !busy_r;
  wire busyNxt = issue | (busy_r & ~doneEvt & readySync);

  wire [REG_DATA_W-1:0] statusWord = {{(REG_DATA_W-5){1'b0}}, pinSync[2], pinSync[1],
                                      pinSync[0], busy_r, readySync};
  wire [REG_DATA_W-1:0] rdMux =
    (regAddr == REG_COL) ? colReg_r :
    (regAddr == REG_WDATA) ? wdataReg_r :
    (regAddr == REG_RDATA) ? rdataReg_r :
    (regAddr == REG_STATUS) ? statusWord :
    (regAddr == REG_CFG) ? {{(REG_DATA_W-1){1'b0}}, cfgDrive_r} :
    '0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      colReg_r <= '0;
      wdataReg_r <= '0;
      cfgDrive_r <= 1'b0;
      regRdata <= '0;
    end else begin
      if (wrCol) colReg_r <= regWdata;
      if (wrWdata) wdataReg_r <= regWdata;
      if (wrCfg) cfgDrive_r <= regWdata[CFG_DRIVE_BIT];
      regRdata <= regRd ? rdMux : '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
      reqTog_r <= 1'b0;
      donePrev_r <= 1'b0;
      sysReq_r <= '0;
      rdataReg_r <= '0;
    end else begin
      busy_r <= busyNxt;
      donePrev_r <= doneSync;
      if (issue) begin
        reqTog_r <= ~reqTog_r;
        sysReq_r <= {regWdata[CMD_WR_BIT], regWdata[CMD_BANK_LSB +: MEM_BANK_W],
                     regWdata[CMD_ROW_LSB +: MEM_ADDR_W], colReg_r[MEM_ADDR_W-1:0],
                     wdataReg_r};
      end
      // Held word is stable: link side only rewrites it on the next request
      if (doneEvt) rdataReg_r <= {{(REG_DATA_W-DQ_W){1'b0}}, rdHold_r};
    end
  end

  // Open drain: the line is only ever pulled low, never driven high
  assign cfgSerialDataDriveEn = cfgDrive_r;

  // ****************************************
  // Link domain: startup sequencer and pads
  // ****************************************
  seq_state_t state_r, stateNxt;
  logic [15:0] cnt_r, cntNxt;
  logic [1:0] mrsIdx_r, mrsIdxNxt;
  padcmd_t cmd_r, cmdNxt;
  logic [MEM_ADDR_W-1:0] addrNxt;
  logic [MEM_BANK_W-1:0] bankNxt;
  memreq_t req_r;
  logic reqSeen_r;
  logic goPrev_r;
  logic takeReq;
  logic finish;
  logic [2:0] ctlSync;
  logic reqSync;
  logic [DQ_W-1:0] dqSync;

  sync_two_flop #(.WIDTH(4)) u_ctl_sync (
    .clk(phyFastClock),
    .rstn(rstn),
    .d({reqTog_r, cfgRstN, startupSequencerGo, startupSequencerReset}),
    .q({reqSync, ctlSync})
  );

  sync_two_flop #(.WIDTH(DQ_W)) u_dq_sync (
    .clk(phyFastClock),
    .rstn(rstn),
    .d(memDqIn),
    .q(dqSync)
  );

  // Controller steps once per memory clock period, so both run at one rate
  wire step = memClkP;
  wire holdIdle = ctlSync[0] | ~ctlSync[2];
  wire goRise = ctlSync[1] & ~goPrev_r;
  wire reqPending = reqSync ^ reqSeen_r;
  wire cntZero = (cnt_r == 16'h0000);

  always_comb begin
    stateNxt = state_r;
    cntNxt = cntZero ? cnt_r : cnt_r - 16'h0001;
    mrsIdxNxt = mrsIdx_r;
    cmdNxt = CMD_NOP;
    addrNxt = memAddr;
    bankNxt = memBank;
    takeReq = 1'b0;
    finish = 1'b0;
    unique case (state_r)
      S_IDLE: begin
        cmdNxt = CMD_DESEL;
        if (goRise) begin
          stateNxt = S_RSTHOLD;
          cntNxt = RST_HOLD_CYC;
        end
      end
      S_RSTHOLD: begin
        cmdNxt = CMD_DESEL;
        if (cntZero) begin
          stateNxt = S_CKEWAIT;
          cntNxt = CKE_WAIT_CYC;
        end
      end
      S_CKEWAIT: begin
        if (cntZero) begin
          stateNxt = S_MRS;
          mrsIdxNxt = 2'h0;
        end
      end
      S_MRS: begin
        if (cntZero) begin
          cmdNxt = CMD_MRS;
          bankNxt = mrsBank(mrsIdx_r);
          addrNxt = mrsValue(mrsIdx_r);
          cntNxt = MRD_CYC;
          mrsIdxNxt = mrsIdx_r + 2'h1;
          if (mrsIdx_r == 2'(MRS_COUNT - 1)) stateNxt = S_ZQ;
        end
      end
      S_ZQ: begin
        if (cntZero) begin
          cmdNxt = CMD_ZQ;
          addrNxt = '0;
          addrNxt[PRE_ALL_BIT] = 1'b1;
          cntNxt = ZQ_CYC;
          stateNxt = S_ZQWAIT;
        end
      end
      S_ZQWAIT: begin
        if (cntZero) stateNxt = S_READY;
      end
      S_READY: begin
        if (reqPending) begin
          takeReq = 1'b1;
          cmdNxt = CMD_ACT;
          addrNxt = sysReq_r.row;
          bankNxt = sysReq_r.bank;
          cntNxt = TRCD_CYC;
          stateNxt = S_TRCD;
        end
      end
      S_TRCD: begin
        if (cntZero) begin
          cmdNxt = req_r.isWrite ? CMD_WR : CMD_RD;
          addrNxt = req_r.col;
          cntNxt = req_r.isWrite ? CWL_CYC : CL_CYC;
          stateNxt = S_LAT;
        end
      end
      S_LAT: begin
        if (cntZero) begin
          cntNxt = BEATS - 16'h0001;
          stateNxt = S_DATA;
        end
      end
      S_DATA: begin
        if (cntZero) begin
          cmdNxt = CMD_PRE;
          addrNxt = '0;
          addrNxt[PRE_ALL_BIT] = 1'b1;
          cntNxt = TRP_CYC;
          stateNxt = S_PRE;
        end
      end
      S_PRE: begin
        if (cntZero) begin
          finish = 1'b1;
          stateNxt = S_READY;
        end
      end
    endcase
    if (holdIdle) begin
      stateNxt = S_IDLE;
      cmdNxt = CMD_DESEL;
      finish = 1'b0;
      takeReq = 1'b0;
    end
  end

  wire writeWinNxt = req_r.isWrite && (stateNxt == S_DATA);
  wire odtNxt = req_r.isWrite && ((stateNxt == S_LAT) || (stateNxt == S_DATA));
  wire ckeNxt = (stateNxt != S_IDLE) && (stateNxt != S_RSTHOLD);
  wire memRstNxt = (stateNxt != S_IDLE) && (stateNxt != S_RSTHOLD);
  wire capture = (state_r == S_DATA) && !req_r.isWrite && (cnt_r == CAP_CNT);
  wire readyNxt = (stateNxt != S_IDLE) && (stateNxt >= S_READY);

  always_ff @(posedge phyFastClock or negedge rstn) begin
    if (!rstn) begin
      memClkP <= 1'b0;
      memClkN <= 1'b1;
    end else begin
      memClkP <= ~memClkP;
      memClkN <= memClkP;
    end
  end

  always_ff @(posedge phyFastClock or negedge rstn) begin
    if (!rstn) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
      mrsIdx_r <= '0;
      goPrev_r <= 1'b0;
      reqSeen_r <= 1'b0;
      req_r <= '0;
      doneTog_r <= 1'b0;
      readyLvl_r <= 1'b0;
      rdHold_r <= '0;
    end else if (step) begin
      state_r <= stateNxt;
      cnt_r <= cntNxt;
      mrsIdx_r <= mrsIdxNxt;
      goPrev_r <= ctlSync[1];
      readyLvl_r <= readyNxt;
      // Stale requests are dropped while unconfigured
      if (takeReq || holdIdle) reqSeen_r <= reqSync;
      if (takeReq) req_r <= sysReq_r;
      if (finish) doneTog_r <= ~doneTog_r;
      if (capture) rdHold_r <= dqSync;
    end
  end

  always_ff @(posedge phyFastClock or negedge rstn) begin
    if (!rstn) begin
      cmd_r <= CMD_DESEL;
      memAddr <= '0;
      memBank <= '0;
      memCke <= 1'b0;
      memRstN <= 1'b0;
      memTerminationCtl <= 1'b0;
      memDqOe <= 1'b0;
      memDqOut <= '0;
      memByteMask <= '1;
    end else if (step) begin
      cmd_r <= cmdNxt;
      memAddr <= addrNxt;
      memBank <= bankNxt;
      memCke <= ckeNxt;
      memRstN <= memRstNxt;
      memTerminationCtl <= odtNxt;
      memDqOe <= writeWinNxt;
      memDqOut <= req_r.wdata[DQ_W-1:0];
      memByteMask <= writeWinNxt ? '0 : '1;
    end
  end

  assign memCsN = cmd_r.csN;
  assign memRasN = cmd_r.rasN;
  assign memCasN = cmd_r.casN;
  assign memWeN = cmd_r.weN;

  // Strobe follows the fast clock; enabled and released one fast clock after the data bus
  always_ff @(posedge phyFastClock or negedge rstn) begin
    if (!rstn) begin
      memStrobeOe <= 1'b0;
      memStrobeOut <= '0;
      memStrobeNOut <= '1;
      memCalPinOut <= 1'b0;
      memCalPinOe <= 1'b0;
    end else begin
      memStrobeOe <= memDqOe;
      memStrobeOut <= memDqOe ? {STROBE_W{~memStrobeOut[0]}} : '0;
      memStrobeNOut <= memDqOe ? {STROBE_W{memStrobeOut[0]}} : '1;
      // Calibration pin carries only an external resistor; never driven
      memCalPinOut <= 1'b0;
      memCalPinOe <= 1'b0;
    end
  end

endmodule

/* src/ddr_pins_pkg.sv */
// Shared constants, carriers and state types of the DDR pad and startup block
package ddr_pins_pkg;

  // ****************************************
  // Register port
  // ****************************************
  localparam int REG_ADDR_W = 5;
  localparam int REG_DATA_W = 32;
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_COL = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_RDATA = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_CFG = 5'h14;

  localparam int CMD_ROW_LSB = 0;
  localparam int CMD_BANK_LSB = 16;
  localparam int CMD_WR_BIT = 19;
  localparam int CMD_GO_BIT = 20;
  localparam int CFG_DRIVE_BIT = 0;
  localparam int ST_READY_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_SCL_BIT = 2;
  localparam int ST_SDA_BIT = 3;
  localparam int ST_CAL_BIT = 4;

  // ****************************************
  // Memory pads
  // ****************************************
  localparam int MEM_ADDR_W = 16;
  localparam int MEM_BANK_W = 3;
  localparam int PRE_ALL_BIT = 10;
  localparam int MRS_COUNT = 4;

  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
  } padcmd_t;

  localparam padcmd_t CMD_DESEL = 4'hF;
  localparam padcmd_t CMD_NOP = 4'h7;
  localparam padcmd_t CMD_ACT = 4'h3;
  localparam padcmd_t CMD_RD = 4'h5;
  localparam padcmd_t CMD_WR = 4'h4;
  localparam padcmd_t CMD_PRE = 4'h2;
  localparam padcmd_t CMD_MRS = 4'h0;
  localparam padcmd_t CMD_ZQ = 4'h6;

  typedef struct packed {
    logic isWrite;
    logic [MEM_BANK_W-1:0] bank;
    logic [MEM_ADDR_W-1:0] row;
    logic [MEM_ADDR_W-1:0] col;
    logic [REG_DATA_W-1:0] wdata;
  } memreq_t;

  typedef enum logic [3:0] {
    S_IDLE,
    S_RSTHOLD,
    S_CKEWAIT,
    S_MRS,
    S_ZQ,
    S_ZQWAIT,
    S_READY,
    S_TRCD,
    S_LAT,
    S_DATA,
    S_PRE
  } seq_state_t;

endpackage

/* src/sync_two_flop.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

/* bench/ddr_pins_asserts.sv */
// Port-level checks of the DDR pad and startup block
`timescale 1ns/1ps
module ddr_pins_asserts
  import ddr_pins_pkg::*;
#(
  parameter int DQ_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [REG_DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic startupSequencerReset,
  input wire logic cfgRstN,
  input wire logic cfgSerialDataDriveEn,
  input wire logic phyFastClock,
  input wire logic [MEM_ADDR_W-1:0] memAddr,
  input wire logic memCsN,
  input wire logic memCke,
  input wire logic memClkP,
  input wire logic memClkN,
  input wire logic memDqOe,
  input wire logic [DQ_W/8-1:0] memByteMask,
  input wire logic [DQ_W/8-1:0] memStrobeOut,
  input wire logic [DQ_W/8-1:0] memStrobeNOut,
  input wire logic memStrobeOe,
  input wire logic memTerminationCtl,
  input wire logic memRstN
);
  // ****************
  // Link domain
  // ****************
  // Six fast clock edges cover the two-flop sync plus the output register
  a_seq_rst_idle: assert property (@(posedge phyFastClock) disable iff (!rstn)
    startupSequencerReset [*6] |-> !memCke && !memRstN && memCsN)
    else $error("sequencer reset did not idle the pads");
  a_master_rst_idle: assert property (@(posedge phyFastClock) disable iff (!rstn)
    !cfgRstN [*6] |-> !memCke && !memRstN && memCsN)
    else $error("master reset did not idle the pads");
  a_pads_on_step: assert property (@(posedge phyFastClock) disable iff (!rstn)
    $changed(memAddr) |-> !memClkP)
    else $error("address moved off a step edge");
  a_cke_needs_rst: assert property (@(posedge phyFastClock) disable iff (!rstn)
    !memRstN |-> !memCke)
    else $error("clock enable high while memory held in reset");
  a_clk_pair: assert property (@(posedge phyFastClock) disable iff (!rstn)
    memClkN == !memClkP)
    else $error("memory clock pair not complementary");
  a_clk_toggle: assert property (@(posedge phyFastClock) disable iff (!rstn)
    $past(rstn) |-> memClkP != $past(memClkP))
    else $error("memory clock did not toggle");
  a_mask_on_beat: assert property (@(posedge phyFastClock) disable iff (!rstn)
    memByteMask == {(DQ_W/8){!memDqOe}})
    else $error("byte mask wrong for data beat");
  a_strobe_follow: assert property (@(posedge phyFastClock) disable iff (!rstn)
    memStrobeOe == $past(memDqOe))
    else $error("strobe enable not one clock after data enable");
  a_strobe_diff: assert property (@(posedge phyFastClock) disable iff (!rstn)
    memStrobeOe |-> memStrobeOut == ~memStrobeNOut)
    else $error("strobe pair not complementary");
  a_odt_on_write: assert property (@(posedge phyFastClock) disable iff (!rstn)
    memDqOe |-> memTerminationCtl)
    else $error("termination low during write beat");
  // ****************
  // Register domain check, then covers of both domains
  // ****************
  a_cfg_drive: assert property (@(posedge clk) disable iff (!rstn)
    regWr && regAddr == REG_CFG |=> cfgSerialDataDriveEn == $past(regWdata[CFG_DRIVE_BIT]))
    else $error("data line drive enable not from config write");
  c_write_beat: cover property (@(posedge phyFastClock) disable iff (!rstn) $rose(memDqOe));
  c_cke_up: cover property (@(posedge phyFastClock) disable iff (!rstn) $rose(memCke));
  c_cfg_write: cover property (@(posedge clk) disable iff (!rstn) regWr && regAddr == REG_CFG);
endmodule

bind ddr_memory_pins_and_startup ddr_pins_asserts #(.DQ_W(DQ_W)) i_ddr_pins_asserts (.*);

/* bench/mem_device_model.sv */
// Behavioural memory device on the far side of the pads
`timescale 1ns/1ps
module mem_device_model
  import ddr_pins_pkg::*;
#(
  parameter int DQ_W = 16,
  parameter int RD_WIN = 40
) (
  input wire logic phyFastClock,
  input wire logic rstn,
  input wire padcmd_t memCmd,
  input wire logic [DQ_W-1:0] memDqOut,
  input wire logic memDqOe,
  output logic [DQ_W-1:0] memDqIn
);
  logic [DQ_W-1:0] store;
  int rdLeft;
  always @(posedge phyFastClock or negedge rstn) begin
    if (!rstn) begin
      store <= '0;
      rdLeft <= 0;
    end else begin
      if (memDqOe) begin
        store <= memDqOut;
      end
      if (memCmd == CMD_RD) begin
        rdLeft <= RD_WIN;
      end else if (rdLeft > 0) begin
        rdLeft <= rdLeft - 1;
      end
    end
  end
  // Outside a read burst show the inverse, so stale capture cannot match
  assign memDqIn = (rdLeft > 0 && !memDqOe) ? store : ~store;
endmodule

/* bench/ddr_memory_pins_and_startup_tb.sv */
// Self-checking bench of the DDR pad and startup block
`timescale 1ns/1ps
module ddr_memory_pins_and_startup_tb;
  import ddr_pins_pkg::*;
  localparam int DQ_W = 16;
  logic clk = 0, phyFastClock = 0, rstn = 1;
  logic [4:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic regWr, regRd, startupSequencerReset, startupSequencerGo, cfgRstN;
  logic cfgSerialClkIn, cfgSerialDataIn, cfgSerialDataDriveEn, memCalPinIn;
  logic [15:0] memAddr, memDqOut, memDqIn, actRow, wrCol, dqSeen;
  logic [2:0] memBank, actBank;
  logic memCsN, memRasN, memCasN, memWeN, memCke, memClkP, memClkN, memDqOe;
  logic [1:0] memByteMask, memStrobeOut, memStrobeNOut;
  logic memStrobeOe, memTerminationCtl, memRstN, memCalPinOut, memCalPinOe;
  padcmd_t memCmd;
  int n_mismatch = 0, checks_done = 0, nMrs = 0;
  assign memCmd = padcmd_t'({memCsN, memRasN, memCasN, memWeN});
  ddr_memory_pins_and_startup #(.DQ_W(DQ_W), .RST_HOLD_CYC(16'h0004),
    .CKE_WAIT_CYC(16'h0002), .ZQ_CYC(16'h0004)) i_ddr_memory_pins_and_startup (.*);
  mem_device_model #(.DQ_W(DQ_W)) i_mem_device_model (.phyFastClock(phyFastClock),
    .rstn(rstn), .memCmd(memCmd), .memDqOut(memDqOut), .memDqOe(memDqOe), .memDqIn(memDqIn));
  // ****************
  // Clocks and pad monitor
  // ****************
  always #2.5 clk = ~clk;
  initial begin
    // First link edge falls inside reset, so its samples start from reset values
    #6;
    forever #62.5 phyFastClock = ~phyFastClock;
  end
  // Commands are read only on step edges, where they have stood two clocks
  always @(posedge phyFastClock) begin
    if (memClkP) begin
      case (memCmd)
        CMD_MRS: nMrs++;
        CMD_ACT: {actRow, actBank} = {memAddr, memBank};
        CMD_WR, CMD_RD: wrCol = memAddr;
        default: ;
      endcase
    end
    if (memDqOe) dqSeen = memDqOut;
  end
  // ****************
  // Tasks
  // ****************
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(logic [4:0] a, logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic wait_status(int b, logic v);
    logic [31:0] s;
    for (int i = 0; i < 3000; i++) begin
      rd(REG_STATUS, s);
      if (s[b] === v) return;
    end
    check("status wait", 1'h0, 1'h1);
    report_and_stop();
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_idle();
    logic [31:0] s;
    startupSequencerGo <= 1'b1;
    repeat (400) @(posedge clk);
    rd(REG_STATUS, s);
    check("ready under seq reset", s[ST_READY_BIT], 1'h0);
    check("cmd idle", memCmd, CMD_DESEL);
    check("cke idle", memCke, 1'h0);
    check("mem reset idle", memRstN, 1'h0);
    check("mask idle", memByteMask, 2'h3);
    check("pin status", s[4:2], 3'h6);
    rd(5'h18, s);
    check("unmapped read", s, 32'h0000_0000);
  endtask
  task automatic t_startup();
    startupSequencerReset <= 1'b0;
    startupSequencerGo <= 1'b0;
    repeat (200) @(posedge clk);
    nMrs = 0;
    startupSequencerGo <= 1'b1;
    wait_status(ST_READY_BIT, 1'b1);
    check("mode writes", nMrs, MRS_COUNT);
    check("cke on", memCke, 1'h1);
    check("mem reset off", memRstN, 1'h1);
  endtask
  task automatic t_cfg();
    wr(REG_CFG, 32'h0000_0001);
    #1 check("drive on", cfgSerialDataDriveEn, 1'h1);
    wr(REG_CFG, 32'h0000_0000);
    #1 check("drive off", cfgSerialDataDriveEn, 1'h0);
  endtask
  task automatic t_access(logic w, logic [15:0] row, logic [2:0] bank, logic [15:0] col,
      logic [31:0] d);
    logic [31:0] s;
    wr(REG_COL, {16'h0000, col});
    wr(REG_WDATA, d);
    wr(REG_CMD, {11'h000, 1'b1, w, bank, row});
    wait_status(ST_BUSY_BIT, 1'b0);
    check("row", actRow, row);
    check("bank", actBank, bank);
    check("col", wrCol, col);
    if (w) begin
      check("write data", dqSeen, d[15:0]);
    end else begin
      rd(REG_RDATA, s);
      check("read data", s, d[15:0]);
    end
  endtask
  task automatic t_master_rst();
    logic [31:0] s;
    cfgRstN <= 1'b0;
    repeat (400) @(posedge clk);
    wr(REG_CMD, 32'h0010_0001);
    rd(REG_STATUS, s);
    check("ready after master reset", s[ST_READY_BIT], 1'h0);
    check("no access before reinit", s[ST_BUSY_BIT], 1'h0);
    check("cke after master reset", memCke, 1'h0);
    cfgRstN <= 1'b1;
  endtask
  initial begin
    // A falling edge at once resets the link side before its clock runs
    rstn <= 1'b0;
    {regAddr, regWdata, regWr, regRd, startupSequencerGo, cfgSerialClkIn} = '0;
    {startupSequencerReset, cfgRstN, cfgSerialDataIn, memCalPinIn} = 4'hF;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_idle();
    t_startup();
    t_cfg();
    t_access(1'b1, 16'hA5C3, 3'h7, 16'h03F8, 32'h5A3C_96E1);
    t_access(1'b0, 16'h0000, 3'h0, 16'hFFFF, 32'h0000_96E1);
    t_master_rst();
    t_startup();
    t_access(1'b0, 16'hFFFF, 3'h2, 16'h0001, 32'h0000_96E1);
    report_and_stop();
  end
endmodule
